// ==== logic/bseh_defines.svh ====
// Constants of the secondary-bus error handler of the bridge
// Assumes byte addresses on a 32-bit Avalon-MM register port
// What this block does
// [R1] Address parity error, enabled: target-abort, discard
// [R2] Attribute parity error, enabled: target-abort, discard
// [R3] Set parity-detected always, signaled-abort on abort
// [R4] Log header, pointer when unmasked, pointer invalid
// [R5] Fatal/non-fatal message by severity, mask, enables
// [R6] System-error status when message sent with enable
// [R7] Set fatal or non-fatal detected by severity
// [R8] Unsupported completion with abort control: target-abort
// [R9] Unsupported read, control clear: all-ones, normal end
// [R10] Unsupported write, control clear: normal end, discard
// [R11] Unsupported completion sets primary received-master-abort
// [R12] Completer abort sets secondary received-target-abort
// [R13] PCI mode: deliver data, then target-abort
// [R14] That target-abort sets primary received-target-abort
// [R15] Class 1 codes map to UR or CA
// [R16] Class 2 codes map to UR or CA
// [R17] CA answer to message sets signaled-abort
// [R18] Master-abort message: UR, received-master-abort bits
// [R19] Target-abort message: CA, received-target-abort bits
// [R20] Completer reports failure with completer-error message
`ifndef BSEH_DEFINES_SVH
`define BSEH_DEFINES_SVH
// ==========================================
// Register offsets
`define BSEH_OFF_CTRL 6'h00
`define BSEH_OFF_MASK 6'h04
`define BSEH_OFF_SEV 6'h08
`define BSEH_OFF_SEC 6'h0C
`define BSEH_OFF_PRI 6'h10
`define BSEH_OFF_DEV 6'h14
`define BSEH_OFF_UNC 6'h18
`define BSEH_OFF_PTR 6'h1C
`define BSEH_OFF_HDR 6'h20
// ==========================================
// Control bits
`define BSEH_C_PERESP 0
`define BSEH_C_SERR 1
`define BSEH_C_FTL 2
`define BSEH_C_NFTL 3
`define BSEH_C_UAA 4
// Uncorrectable error index (mask, severity, status)
`define BSEH_E_ADDR 0
`define BSEH_E_ATTR 1
`define BSEH_E_RMA 2
`define BSEH_E_RTA 3
// Secondary status bits
`define BSEH_S_DPE 0
`define BSEH_S_STA 1
`define BSEH_S_RTA 2
`define BSEH_S_RMA 3
// Primary status bits
`define BSEH_P_RMA 0
`define BSEH_P_RTA 1
`define BSEH_P_STA 2
`define BSEH_P_SSERR 3
// Device status bits
`define BSEH_D_FTL 0
`define BSEH_D_NFTL 1
// Pointer valid bit
`define BSEH_PTR_V 2
// ==========================================
// Reset values and fixed data
`define BSEH_RST_CTRL 5'h00
`define BSEH_RST_MASK 4'h0
`define BSEH_RST_SEV 4'h0
`define BSEH_ONES 32'hFFFF_FFFF
// ==========================================
// Completer-error message codes
`define BSEH_CLS1 4'h1
`define BSEH_CLS2 4'h2
`define BSEH_IX0 8'h00
`define BSEH_IX1 8'h01
`define BSEH_IX2 8'h02
`define BSEH_IXDEV 4'h8
`endif

// ==== logic/bseh_pkg.sv ====
// Types of the secondary-bus error handler
// Assumes nothing from the defines header; its figures are literal
package bseh_pkg;
    // Completer-abort delivery sequence, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DRAIN = 3'h2,
        ST_ABORT = 3'h4
    } bseh_state_e;
    // Upstream completion status codes
    typedef enum logic [2:0] {
        CPL_SC = 3'h0,
        CPL_UR = 3'h1,
        CPL_CA = 3'h4
    } bseh_cpl_e;
endpackage

// ==== logic/bseh_top.sv ====
// Secondary-bus error handler: status, logging, messages, answers
// Assumes event inputs come from logic on the same clock
`timescale 1ns/1ps
`include "bseh_defines.svh"
module bseh_top
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sec_addr_err,
    input wire logic sec_attr_err,
    input wire logic [31:0] err_hdr,
    input wire logic ur_cpl,
    input wire logic ca_cpl,
    input wire logic req_is_read,
    input wire logic pci_mode,
    input wire logic cpl_data_left,
    input wire logic scm_valid,
    input wire logic [3:0] scm_class,
    input wire logic [7:0] scm_index,
    output logic ta_out,
    output logic trdy_out,
    output logic discard_out,
    output logic [31:0] rdata_out,
    output logic rdata_valid,
    output logic [2:0] cpl_status_out,
    output logic cpl_valid,
    output logic msg_valid,
    output logic msg_fatal
);
    logic ack_r;
    logic [4:0] ctrl_r;
    logic [3:0] mask_r;
    logic [3:0] sev_r;
    logic [3:0] sec_r;
    logic [3:0] pri_r;
    logic [1:0] dev_r;
    logic [3:0] unc_r;
    logic [2:0] ptr_r;
    logic [31:0] hdr_r;
    bseh_pkg::bseh_state_e st_r;
    bseh_pkg::bseh_state_e st_nxt;

    // ==========================================
    // Avalon slave: one wait state per access
    wire acc = avs_read | avs_write;
    wire take = acc & ack_r;
    assign avs_waitrequest = acc & ~ack_r;
    wire wr = avs_write & take & avs_byteenable[0];
    wire hit_ctrl = avs_address == `BSEH_OFF_CTRL;
    wire hit_mask = avs_address == `BSEH_OFF_MASK;
    wire hit_sev = avs_address == `BSEH_OFF_SEV;
    wire hit_sec = avs_address == `BSEH_OFF_SEC;
    wire hit_pri = avs_address == `BSEH_OFF_PRI;
    wire hit_dev = avs_address == `BSEH_OFF_DEV;
    wire hit_unc = avs_address == `BSEH_OFF_UNC;
    wire hit_ptr = avs_address == `BSEH_OFF_PTR;
    wire hit_hdr = avs_address == `BSEH_OFF_HDR;
    // Write-one-to-clear strobes
    wire [3:0] clr_sec = (wr & hit_sec) ? avs_writedata[3:0] : 4'h0;
    wire [3:0] clr_pri = (wr & hit_pri) ? avs_writedata[3:0] : 4'h0;
    wire [1:0] clr_dev = (wr & hit_dev) ? avs_writedata[1:0] : 2'h0;
    wire [3:0] clr_unc = (wr & hit_unc) ? avs_writedata[3:0] : 4'h0;
    wire clr_ptr = wr & hit_ptr & avs_writedata[`BSEH_PTR_V];
    // Read selection; unmapped reads zero
    wire [31:0] rd_mux =
        hit_ctrl ? {27'h0, ctrl_r} :
        hit_mask ? {28'h0, mask_r} :
        hit_sev ? {28'h0, sev_r} :
        hit_sec ? {28'h0, sec_r} :
        hit_pri ? {28'h0, pri_r} :
        hit_dev ? {30'h0, dev_r} :
        hit_unc ? {28'h0, unc_r} :
        hit_ptr ? {29'h0, ptr_r} :
        hit_hdr ? hdr_r : 32'h0;

    // ==========================================
    // Control fields
    wire perr_en = ctrl_r[`BSEH_C_PERESP];
    wire system_error_enable = ctrl_r[`BSEH_C_SERR];
    wire ftl_en = ctrl_r[`BSEH_C_FTL];
    wire nftl_en = ctrl_r[`BSEH_C_NFTL];
    wire uaa = ctrl_r[`BSEH_C_UAA];

    // ==========================================
    // Split completion message decode
    wire c1 = scm_valid & (scm_class == `BSEH_CLS1);
    wire c2 = scm_valid & (scm_class == `BSEH_CLS2);
    wire m_ma = c1 & (scm_index == `BSEH_IX0);
    wire m_ta = c1 & (scm_index == `BSEH_IX1);
    wire m_wde = c1 & (scm_index == `BSEH_IX2);
    wire m_bc = c2 & (scm_index == `BSEH_IX0);
    wire m_swde = c2 & (scm_index == `BSEH_IX1);
    wire m_dev = c2 & (scm_index[7:4] == `BSEH_IXDEV);
    wire scm_ur = m_ma | m_wde | m_bc | m_swde; // see [R15] see [R16]
    wire scm_ca = m_ta | m_dev; // see [R15] see [R16]

    // ==========================================
    // Parity errors, gated by response enable
    wire addr_ab = sec_addr_err & perr_en; // see [R1]
    wire attr_ab = sec_attr_err & perr_en; // see [R2]
    // Unsupported completion answers
    wire ur_ab = ur_cpl & uaa; // see [R8]
    wire ur_rd = ur_cpl & ~uaa & req_is_read; // see [R9]
    wire ur_wr = ur_cpl & ~uaa & ~req_is_read; // see [R10]
    // Target-abort from the completer-abort sequence
    wire ca_ab = st_r == bseh_pkg::ST_ABORT;
    wire ta_nxt = addr_ab | attr_ab | ur_ab | ca_ab;

    // ==========================================
    // Uncorrectable error vector and qualifiers
    wire [3:0] err;
    assign err[`BSEH_E_ADDR] = addr_ab;
    assign err[`BSEH_E_ATTR] = attr_ab;
    assign err[`BSEH_E_RMA] = m_ma;
    assign err[`BSEH_E_RTA] = m_ta;
    wire [3:0] unm = err & ~mask_r;
    wire unm_any = |unm;
    wire ptr_load = (|unm) & ~ptr_r[`BSEH_PTR_V]; // see [R4]
    wire [1:0] ptr_idx =
        unm[`BSEH_E_ADDR] ? 2'h0 :
        unm[`BSEH_E_ATTR] ? 2'h1 :
        unm[`BSEH_E_RMA] ? 2'h2 : 2'h3;
    // Message choice, one message marked fatal when both qualify
    wire ftl_q = (|(unm & sev_r)) & (system_error_enable | ftl_en); // see [R5]
    wire nftl_q = (|(unm & ~sev_r)) & (system_error_enable | nftl_en); // see [R5]
    wire msg_nxt = ftl_q | nftl_q;

    // ==========================================
    // Status set terms
    wire [3:0] set_sec;
    assign set_sec[`BSEH_S_DPE] = sec_addr_err | sec_attr_err; // see [R3]
    assign set_sec[`BSEH_S_STA] = addr_ab | attr_ab | ur_ab | scm_ca; // see [R3] see [R8] see [R17]
    assign set_sec[`BSEH_S_RTA] = ca_cpl | m_ta; // see [R12] see [R19]
    assign set_sec[`BSEH_S_RMA] = m_ma; // see [R18]
    wire [3:0] set_pri;
    assign set_pri[`BSEH_P_RMA] = ur_cpl; // see [R11]
    assign set_pri[`BSEH_P_RTA] = ca_ab; // see [R14]
    assign set_pri[`BSEH_P_STA] = m_ta; // see [R19]
    assign set_pri[`BSEH_P_SSERR] = msg_nxt & system_error_enable; // see [R6]
    wire [1:0] set_dev;
    assign set_dev[`BSEH_D_FTL] = |(err & sev_r); // see [R7]
    assign set_dev[`BSEH_D_NFTL] = |(err & ~sev_r); // see [R7]

    // ==========================================
    // Completer-abort delivery sequence
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            bseh_pkg::ST_IDLE:
            begin
                if (ca_cpl & pci_mode)
                begin
                    st_nxt = bseh_pkg::ST_DRAIN; // see [R13]
                end
            end
            bseh_pkg::ST_DRAIN:
            begin
                if (!cpl_data_left)
                begin
                    st_nxt = bseh_pkg::ST_ABORT; // see [R13]
                end
            end
            bseh_pkg::ST_ABORT:
            begin
                st_nxt = bseh_pkg::ST_IDLE;
            end
            default:
            begin
                st_nxt = bseh_pkg::ST_IDLE;
            end
        endcase
    end

    // Bus handshake and read data
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ack_r <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else if (ce)
        begin
            ack_r <= acc & ~ack_r;
            avs_readdata <= (avs_read & ~ack_r) ? rd_mux : avs_readdata;
        end
    end

    // Software-owned control registers
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ctrl_r <= `BSEH_RST_CTRL;
            mask_r <= `BSEH_RST_MASK;
            sev_r <= `BSEH_RST_SEV;
        end
        else if (ce & wr)
        begin
            ctrl_r <= hit_ctrl ? avs_writedata[4:0] : ctrl_r;
            mask_r <= hit_mask ? avs_writedata[3:0] : mask_r;
            sev_r <= hit_sev ? avs_writedata[3:0] : sev_r;
        end
    end

    // Sticky status: a set in the clear cycle wins
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            sec_r <= 4'h0;
            pri_r <= 4'h0;
            dev_r <= 2'h0;
            unc_r <= 4'h0;
        end
        else if (ce)
        begin
            sec_r <= (sec_r & ~clr_sec) | set_sec;
            pri_r <= (pri_r & ~clr_pri) | set_pri;
            dev_r <= (dev_r & ~clr_dev) | set_dev;
            unc_r <= (unc_r & ~clr_unc) | err; // see [R18] see [R19]
        end
    end

    // First-error pointer and header log
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ptr_r <= 3'h0;
            hdr_r <= 32'h0;
        end
        else if (ce)
        begin
            if (ptr_load)
            begin
                ptr_r <= {1'b1, ptr_idx}; // see [R4]
                hdr_r <= err_hdr; // see [R4]
            end
            else if (clr_ptr)
            begin
                ptr_r <= 3'h0;
            end
        end
    end

    // Answers to the secondary master and upstream
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            st_r <= bseh_pkg::ST_IDLE;
            ta_out <= 1'b0;
            trdy_out <= 1'b0;
            discard_out <= 1'b0;
            rdata_out <= 32'h0;
            rdata_valid <= 1'b0;
            cpl_status_out <= bseh_pkg::CPL_SC;
            cpl_valid <= 1'b0;
            msg_valid <= 1'b0;
            msg_fatal <= 1'b0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            ta_out <= ta_nxt; // see [R1] see [R2] see [R8] see [R13]
            trdy_out <= ur_rd | ur_wr; // see [R9] see [R10]
            discard_out <= addr_ab | attr_ab | ur_wr; // see [R1] see [R2] see [R10]
            rdata_out <= ur_rd ? `BSEH_ONES : 32'h0; // see [R9]
            rdata_valid <= ur_rd;
            cpl_valid <= scm_ur | scm_ca;
            cpl_status_out <= scm_ca ? bseh_pkg::CPL_CA :
                scm_ur ? bseh_pkg::CPL_UR : bseh_pkg::CPL_SC; // see [R15] see [R16]
            msg_valid <= msg_nxt; // see [R5]
            msg_fatal <= ftl_q; // see [R5]
        end
    end

    // ==========================================
    // Checks
    property p_r1;
        @(posedge clock) disable iff (!rstn)
        ce & sec_addr_err & perr_en |=> ta_out & discard_out;
    endproperty
    a_r1: assert property (p_r1) else $error("address error not aborted"); // see [R1]
    property p_r3;
        @(posedge clock) disable iff (!rstn)
        ce & sec_attr_err |=> sec_r[`BSEH_S_DPE];
    endproperty
    a_r3: assert property (p_r3) else $error("parity detected not set"); // see [R3]
    property p_r4;
        @(posedge clock) disable iff (!rstn)
        ce & ptr_r[`BSEH_PTR_V] & ~clr_ptr |=> $stable(hdr_r) & ptr_r[`BSEH_PTR_V];
    endproperty
    a_r4: assert property (p_r4) else $error("header log overwritten"); // see [R4]
    property p_r5;
        @(posedge clock) disable iff (!rstn)
        $past(ce) & msg_valid |-> $past(unm_any) & (msg_fatal == $past(ftl_q));
    endproperty
    a_r5: assert property (p_r5) else $error("message without cause"); // see [R5]
    property p_r6;
        @(posedge clock) disable iff (!rstn)
        ce & msg_nxt & system_error_enable |=> pri_r[`BSEH_P_SSERR];
    endproperty
    a_r6: assert property (p_r6) else $error("system error status missing"); // see [R6]
    property p_r9;
        @(posedge clock) disable iff (!rstn)
        ce & ur_cpl & ~uaa & req_is_read |=> trdy_out & (rdata_out == `BSEH_ONES) & ~ta_out;
    endproperty
    a_r9: assert property (p_r9) else $error("unsupported read not all ones"); // see [R9]
    property p_r11;
        @(posedge clock) disable iff (!rstn)
        ce & ur_cpl |=> pri_r[`BSEH_P_RMA];
    endproperty
    a_r11: assert property (p_r11) else $error("primary master abort missing"); // see [R11]
    property p_r13;
        @(posedge clock) disable iff (!rstn)
        ce & (st_r == bseh_pkg::ST_DRAIN) & cpl_data_left
            & ~sec_addr_err & ~sec_attr_err & ~ur_cpl |=> ~ta_out;
    endproperty
    a_r13: assert property (p_r13) else $error("abort before data delivered"); // see [R13]
    property p_r19;
        @(posedge clock) disable iff (!rstn)
        ce & m_ta |=> cpl_valid & (cpl_status_out == bseh_pkg::CPL_CA)
            & pri_r[`BSEH_P_STA] & unc_r[`BSEH_E_RTA] & sec_r[`BSEH_S_STA]
            & sec_r[`BSEH_S_RTA];
    endproperty
    a_r19: assert property (p_r19) else $error("target abort message mishandled"); // see [R19]
    // Remaining answers and status updates
    property p_r2;
        @(posedge clock) disable iff (!rstn)
        ce & sec_attr_err & perr_en |=> ta_out & discard_out;
    endproperty
    a_r2: assert property (p_r2) else $error("attribute error not aborted"); // see [R2]
    property p_r7;
        @(posedge clock) disable iff (!rstn)
        ce & sec_addr_err & perr_en & sev_r[`BSEH_E_ADDR] |=> dev_r[`BSEH_D_FTL];
    endproperty
    a_r7: assert property (p_r7) else $error("fatal detected not set"); // see [R7]
    property p_r8;
        @(posedge clock) disable iff (!rstn)
        ce & ur_cpl & uaa |=> ta_out & ~trdy_out & sec_r[`BSEH_S_STA];
    endproperty
    a_r8: assert property (p_r8) else $error("unsupported not aborted"); // see [R8]
    property p_r10;
        @(posedge clock) disable iff (!rstn)
        ce & ur_cpl & ~uaa & ~req_is_read |=> trdy_out & discard_out & ~rdata_valid;
    endproperty
    a_r10: assert property (p_r10) else $error("unsupported write not ended"); // see [R10]
    property p_r12;
        @(posedge clock) disable iff (!rstn)
        ce & ca_cpl |=> sec_r[`BSEH_S_RTA];
    endproperty
    a_r12: assert property (p_r12) else $error("secondary target abort missing"); // see [R12]
    property p_r14;
        @(posedge clock) disable iff (!rstn)
        ce & ca_ab |=> ta_out & pri_r[`BSEH_P_RTA];
    endproperty
    a_r14: assert property (p_r14) else $error("primary target abort missing"); // see [R14]
    property p_r16;
        @(posedge clock) disable iff (!rstn)
        ce & m_dev |=> cpl_valid & (cpl_status_out == bseh_pkg::CPL_CA) & sec_r[`BSEH_S_STA];
    endproperty
    a_r16: assert property (p_r16) else $error("device error mishandled"); // see [R16] see [R17]
    property p_r18;
        @(posedge clock) disable iff (!rstn)
        ce & m_ma |=> cpl_valid & (cpl_status_out == bseh_pkg::CPL_UR)
            & sec_r[`BSEH_S_RMA] & unc_r[`BSEH_E_RMA];
    endproperty
    a_r18: assert property (p_r18) else $error("master abort message mishandled"); // see [R18]
endmodule

// ==== bench/bseh_far_end.sv ====
// Far-side model: PCI-X completer messages and the return-data path
// Assumes the bench raises msg_go and data_go just after rising edges
`timescale 1ns/1ps
module bseh_far_end
#(
    parameter int BEATS = 3
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic msg_go,
    input wire logic data_go,
    input wire logic [3:0] cls,
    input wire logic [7:0] idx,
    output logic scm_valid,
    output logic [3:0] scm_class,
    output logic [7:0] scm_index,
    output logic cpl_data_left
);
    int left_n;
    // ==========================================
    // Message pulse, code garbage when idle, data beats
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            scm_valid <= 1'b0;
            scm_class <= 4'h0;
            scm_index <= 8'h00;
            left_n <= 0;
        end
        else
        begin
            scm_valid <= msg_go;
            scm_class <= msg_go ? cls : ~scm_class;
            scm_index <= msg_go ? idx : ~scm_index;
            left_n <= data_go ? BEATS : (left_n > 0 ? left_n - 1 : 0);
        end
    end
    assign cpl_data_left = left_n > 0;
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench of the secondary-bus error handler
// Assumes event answers one cycle after the cause; every wait is bounded
`timescale 1ns/1ps
`include "bseh_defines.svh"
module tb_top;
    logic clock, rstn, ce, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, err_hdr, rdata_out, q;
    logic [3:0] avs_byteenable, scm_class, cls;
    logic [7:0] scm_index, idx;
    logic [2:0] cpl_status_out;
    logic sec_addr_err, sec_attr_err, ur_cpl, ca_cpl, req_is_read, pci_mode;
    logic cpl_data_left, scm_valid, ta_out, trdy_out, discard_out, rdata_valid;
    logic cpl_valid, msg_valid, msg_fatal, msg_go, data_go, ta_early, ta_seen;
    int n_mismatch, tests_run, k;
    localparam logic [14:0] TBL [6] = '{{4'h1, 8'h00, bseh_pkg::CPL_UR},
        {4'h1, 8'h01, bseh_pkg::CPL_CA}, {4'h1, 8'h02, bseh_pkg::CPL_UR},
        {4'h2, 8'h00, bseh_pkg::CPL_UR}, {4'h2, 8'h01, bseh_pkg::CPL_UR},
        {4'h2, 8'h85, bseh_pkg::CPL_CA}};
    bseh_top dut_u (.clock, .rstn, .ce, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sec_addr_err, .sec_attr_err, .err_hdr, .ur_cpl, .ca_cpl, .req_is_read,
        .pci_mode, .cpl_data_left, .scm_valid, .scm_class, .scm_index, .ta_out,
        .trdy_out, .discard_out, .rdata_out, .rdata_valid, .cpl_status_out,
        .cpl_valid, .msg_valid, .msg_fatal);
    // Six beats keep data pending well past the completer abort
    bseh_far_end #(.BEATS(6)) far_u (.clock, .rstn, .msg_go, .data_go, .cls, .idx,
        .scm_valid, .scm_class, .scm_index, .cpl_data_left);
    // ==========================================
    // Clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ==========================================
    // Compare, verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================
    // Register access and event pulses
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            n_mismatch++;
            close_out;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task fire(input int w, input logic [31:0] h, input logic r);
        @(posedge clock);
        err_hdr <= h;
        req_is_read <= r;
        {sec_addr_err, sec_attr_err, ur_cpl, ca_cpl} <= 4'h8 >> w;
        @(posedge clock);
        {sec_addr_err, sec_attr_err, ur_cpl, ca_cpl} <= 4'h0;
        @(negedge clock);
    endtask
    task clr_all;
        wr(`BSEH_OFF_SEC, 32'hF);
        wr(`BSEH_OFF_PRI, 32'hF);
        wr(`BSEH_OFF_DEV, 32'h3);
        wr(`BSEH_OFF_UNC, 32'hF);
        wr(`BSEH_OFF_PTR, 32'h4);
        wr(`BSEH_OFF_MASK, 32'h0);
        wr(`BSEH_OFF_CTRL, 32'h0);
    endtask
    // ==========================================
    // Scenarios
    task t_parity;
        fire(0, 32'h1111_0000, 1'b0);
        chk(ta_out, 1'b0);
        rd(`BSEH_OFF_SEC, 32'h1);
        wr(`BSEH_OFF_SEC, 32'hF);
        wr(`BSEH_OFF_CTRL, 32'h3);
        wr(`BSEH_OFF_SEV, 32'h1);
        fire(0, 32'hA5A5_0001, 1'b0);
        chk({ta_out, discard_out, msg_valid, msg_fatal}, 4'hF);
        rd(`BSEH_OFF_SEC, 32'h3);
        rd(`BSEH_OFF_PTR, 32'h4);
        rd(`BSEH_OFF_HDR, 32'hA5A5_0001);
        rd(`BSEH_OFF_PRI, 32'h8);
        rd(`BSEH_OFF_DEV, 32'h1);
        fire(1, 32'h5A5A_0002, 1'b0);
        chk({ta_out, discard_out, msg_valid, msg_fatal}, 4'hE);
        rd(`BSEH_OFF_HDR, 32'hA5A5_0001);
        rd(`BSEH_OFF_DEV, 32'h3);
        wr(`BSEH_OFF_MASK, 32'h1);
        fire(0, 32'h0, 1'b0);
        chk(msg_valid, 1'b0);
        wr(`BSEH_OFF_PRI, 32'hF);
        wr(`BSEH_OFF_MASK, 32'h0);
        wr(`BSEH_OFF_CTRL, 32'h5);
        fire(0, 32'h0, 1'b0);
        chk(msg_valid, 1'b1);
        rd(`BSEH_OFF_PRI, 32'h0);
        clr_all;
    endtask
    task t_ur;
        fire(2, 32'h0, 1'b1);
        chk({trdy_out, rdata_valid, ta_out}, 3'b110);
        chk(rdata_out, `BSEH_ONES);
        rd(`BSEH_OFF_PRI, 32'h1);
        fire(2, 32'h0, 1'b0);
        chk({trdy_out, discard_out, ta_out}, 3'b110);
        wr(`BSEH_OFF_CTRL, 32'h10);
        fire(2, 32'h0, 1'b1);
        chk({ta_out, trdy_out}, 2'b10);
        rd(`BSEH_OFF_SEC, 32'h2);
        clr_all;
    endtask
    // Clock enable low: an event must leave no trace
    task t_hold;
        @(posedge clock);
        ce <= 1'b0;
        fire(2, 32'h0, 1'b1);
        chk(trdy_out, 1'b0);
        @(posedge clock);
        ce <= 1'b1;
        rd(`BSEH_OFF_PRI, 32'h0);
    endtask
    task t_ca;
        @(posedge clock);
        pci_mode <= 1'b1;
        data_go <= 1'b1;
        @(posedge clock);
        data_go <= 1'b0;
        fire(3, 32'h0, 1'b1);
        ta_early = 1'b0;
        ta_seen = 1'b0;
        for (k = 0; k < 20; k++)
        begin
            @(negedge clock);
            ta_early |= ta_out === 1'b1 && cpl_data_left === 1'b1;
            ta_seen |= ta_out === 1'b1;
        end
        chk({ta_early, ta_seen}, 2'b01);
        rd(`BSEH_OFF_PRI, 32'h2);
        rd(`BSEH_OFF_SEC, 32'h4);
        pci_mode <= 1'b0;
        clr_all;
    endtask
    task t_split;
        for (int j = 0; j < 6; j++)
        begin
            @(posedge clock);
            msg_go <= 1'b1;
            {cls, idx} <= TBL[j][14:3];
            @(posedge clock);
            msg_go <= 1'b0;
            k = 0;
            do
            begin
                @(negedge clock);
                k++;
            end while (cpl_valid !== 1'b1 && k < 10);
            chk({cpl_valid, cpl_status_out}, {1'b1, TBL[j][2:0]});
        end
        rd(`BSEH_OFF_SEC, 32'hE);
        rd(`BSEH_OFF_PRI, 32'h4);
        rd(`BSEH_OFF_UNC, 32'hC);
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        {ce, avs_byteenable} = 5'h1F;
        {rstn, avs_read, avs_write, msg_go, data_go, pci_mode} = 6'h0;
        {sec_addr_err, sec_attr_err, ur_cpl, ca_cpl, req_is_read} = 5'h0;
        {avs_address, avs_writedata, err_hdr, cls, idx} = '0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        rd(`BSEH_OFF_CTRL, 32'h0);
        rd(`BSEH_OFF_SEV, 32'h0);
        rd(6'h24, 32'h0);
        t_parity;
        t_ur;
        t_hold;
        t_ca;
        t_split;
        close_out;
    end
endmodule
